// ---- design/qbp_pkg.sv ----
/*
 * Shared constants, pad bundle type and pad helper for the two
 * quasi-bidirectional port latches.
 * Assumes a single core clock and a core that drives the port register
 * strobes synchronously to it.
 */
`default_nettype none
package qbp_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BSEL_W = 3;
  localparam int unsigned XADDR_W = 24;

  // Register addresses in the core's port register space.
  localparam logic [ADDR_W-1:0] UPPER_PORT_ADDR = 8'ha0;
  localparam logic [ADDR_W-1:0] STROBE_PORT_ADDR = 8'hb0;

  localparam logic [PORT_W-1:0] LATCH_RESET = 8'hff;
  localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;
  localparam logic [PORT_W-1:0] ALL_ZEROS = 8'h00;

  // Upper port pin positions.
  localparam int unsigned SCLK_BIT = 0;
  localparam int unsigned MOSI_BIT = 1;
  localparam int unsigned MISO_BIT = 2;
  localparam int unsigned SS_T2_BIT = 3;
  localparam int unsigned TIMER_TWO_EXT_CONTROL_BIT = 4;
  localparam int unsigned PULSE_A_BIT = 5;
  localparam int unsigned PULSE_B_BIT = 6;
  localparam int unsigned PULSE_CLK_BIT = 7;

  // Strobe port pin positions.
  localparam int unsigned RXD_BIT = 0;
  localparam int unsigned TXD_BIT = 1;
  localparam int unsigned IRQ0_BIT = 2;
  localparam int unsigned IRQ1_BIT = 3;
  localparam int unsigned CNT0_BIT = 4;
  localparam int unsigned CNT1_BIT = 5;
  localparam int unsigned WR_STB_BIT = 6;
  localparam int unsigned RD_STB_BIT = 7;

  // External address byte positions inside the 24-bit address.
  localparam int unsigned MID_BYTE_LSB = 8;
  localparam int unsigned HIGH_BYTE_LSB = 16;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] pull;
  } qbp_pad_t;

  // A one is left to the weak pull-up, a zero is driven low.
  function automatic qbp_pad_t qbp_quasi(input logic [PORT_W-1:0] v);
    qbp_pad_t p;
    p.out = ALL_ZEROS;
    p.oe = ~v;
    p.pull = v;
    return p;
  endfunction

endpackage
`default_nettype wire

// ---- design/qbp_latch.sv ----
/*
 * One 8-bit port output latch with byte writes and single-bit
 * read-modify-write updates.
 * Assumes the core never asserts a byte write and a bit write together;
 * if it does, the byte write wins.
 */
`default_nettype none
module qbp_latch (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [qbp_pkg::PORT_W-1:0] wdata_i,
  input wire logic bit_wr_i,
  input wire logic [qbp_pkg::BSEL_W-1:0] bit_sel_i,
  input wire logic bit_val_i,
  output logic [qbp_pkg::PORT_W-1:0] q_o
);
  import qbp_pkg::*;

  logic [PORT_W-1:0] latch_next;

  always_comb begin
    latch_next = q_o;
    if (wr_i) begin
      latch_next = wdata_i;
    end else if (bit_wr_i) begin
      latch_next[bit_sel_i] = bit_val_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= LATCH_RESET;
    end else if (ce_i) begin
      q_o <= latch_next;
    end
  end

endmodule
`default_nettype wire

// ---- design/qbp_ports.sv ----
/*
 * Upper and strobe quasi-bidirectional ports: latches, pad drive,
 * alternate-function multiplexing and latch-or-pin readback.
 * Assumes pins arrive synchronous to clock_i and that the pad cell
 * resolves out/oe/pull into the wire level.
 */
`default_nettype none
//////////////////////////////////////////////////////////////////////////
// Functional notes
// - Upper port latch one leaves pin weakly pulled high as input.
// - Upper port latch zero drives its pin low.
// - External data access puts middle or high address byte on upper port.
// - Selected pulse outputs drive upper bits 5 and 6 over the latch.
// - Upper bit 7 feeds the pulse modulator's alternate clock.
// - Upper bits 0-4: SPI clock, MOSI, MISO, select/timer-two clock, ext control.
// - Strobe port latch one pulls high, latch zero drives low.
// - Strobe port alternate functions act only when the latch holds one.
// - Strobe bits: RX, TX, irq0, irq1, count0, count1, write, read strobes.
// - Read-modify-write reads return the output latch.
// - Other port reads return sampled pin levels.
// - Logic ops, jump-clear, complement, inc, dec, dec-jump read the latch.
// - Bit move, clear, set rewrite whole byte with one bit changed.
module qbp_ports (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [qbp_pkg::ADDR_W-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [qbp_pkg::PORT_W-1:0] sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [qbp_pkg::BSEL_W-1:0] sfr_bit_sel_i,
  input wire logic sfr_bit_val_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_rd_latch_i,
  output logic [qbp_pkg::PORT_W-1:0] sfr_rdata_o,
  input wire logic ext_mem_i,
  input wire logic ext_high_sel_i,
  input wire logic [qbp_pkg::XADDR_W-1:0] ext_addr_i,
  input wire logic pulse_a_en_i,
  input wire logic pulse_b_en_i,
  input wire logic pulse_out_a_i,
  input wire logic pulse_out_b_i,
  input wire logic spi_en_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic uart_rxd_out_i,
  input wire logic uart_txd_i,
  input wire logic wr_strobe_b_i,
  input wire logic rd_strobe_b_i,
  input wire logic [qbp_pkg::PORT_W-1:0] upper_pad_in_i,
  input wire logic [qbp_pkg::PORT_W-1:0] strobe_pad_in_i,
  output qbp_pkg::qbp_pad_t upper_pad_o,
  output qbp_pkg::qbp_pad_t strobe_pad_o,
  output logic spi_miso_o,
  output logic spi_ss_b_o,
  output logic timer_two_clk_o,
  output logic timer_two_ext_control_o,
  output logic pulse_alt_clock_o,
  output logic uart_rxd_o,
  output logic ext_irq_zero_o,
  output logic ext_irq_one_o,
  output logic count_in_zero_o,
  output logic count_in_one_o
);
  import qbp_pkg::*;

  logic [PORT_W-1:0] upper_q;
  logic [PORT_W-1:0] strobe_q;
  logic [PORT_W-1:0] upper_pins_reg;
  logic [PORT_W-1:0] strobe_pins_reg;
  logic [PORT_W-1:0] upper_val;
  logic [PORT_W-1:0] strobe_alt;
  logic [PORT_W-1:0] addr_byte;
  logic [PORT_W-1:0] rdata_next;
  qbp_pad_t upper_pad_next;
  qbp_pad_t strobe_pad_next;
  logic hit_upper;
  logic hit_strobe;

  assign hit_upper = (sfr_addr_i == UPPER_PORT_ADDR);
  assign hit_strobe = (sfr_addr_i == STROBE_PORT_ADDR);

  //////////////////////////////////////////////////////////////////////////
  // Latches.

  qbp_latch u_upper_latch (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .wr_i(sfr_wr_i && hit_upper),
    .wdata_i(sfr_wdata_i),
    .bit_wr_i(sfr_bit_wr_i && hit_upper),
    .bit_sel_i(sfr_bit_sel_i),
    .bit_val_i(sfr_bit_val_i),
    .q_o(upper_q)
  );

  qbp_latch u_strobe_latch (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .wr_i(sfr_wr_i && hit_strobe),
    .wdata_i(sfr_wdata_i),
    .bit_wr_i(sfr_bit_wr_i && hit_strobe),
    .bit_sel_i(sfr_bit_sel_i),
    .bit_val_i(sfr_bit_val_i),
    .q_o(strobe_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // Upper port drive.

  always_comb begin
    upper_val = upper_q;
    if (spi_en_i) begin
      upper_val[SCLK_BIT] = upper_q[SCLK_BIT] & spi_sclk_i;
      upper_val[MOSI_BIT] = upper_q[MOSI_BIT] & spi_mosi_i;
    end
    if (pulse_a_en_i) begin
      upper_val[PULSE_A_BIT] = pulse_out_a_i;
    end
    if (pulse_b_en_i) begin
      upper_val[PULSE_B_BIT] = pulse_out_b_i;
    end
  end

  // Address bytes are driven push-pull so no external pull-ups are needed.
  assign addr_byte = ext_high_sel_i ? ext_addr_i[HIGH_BYTE_LSB +: PORT_W]
                                    : ext_addr_i[MID_BYTE_LSB +: PORT_W];

  always_comb begin
    upper_pad_next = qbp_quasi(upper_val);
    if (ext_mem_i) begin
      upper_pad_next.out = addr_byte;
      upper_pad_next.oe = ALL_ONES;
      upper_pad_next.pull = ALL_ZEROS;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Strobe port drive. Input-only functions idle high so the pin floats up.

  always_comb begin
    strobe_alt = ALL_ONES;
    strobe_alt[RXD_BIT] = uart_rxd_out_i;
    strobe_alt[TXD_BIT] = uart_txd_i;
    strobe_alt[WR_STB_BIT] = wr_strobe_b_i;
    strobe_alt[RD_STB_BIT] = rd_strobe_b_i;
    strobe_pad_next = qbp_quasi(strobe_q & strobe_alt);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_pad_o <= qbp_quasi(LATCH_RESET);
      strobe_pad_o <= qbp_quasi(LATCH_RESET);
    end else if (ce_i) begin
      upper_pad_o <= upper_pad_next;
      strobe_pad_o <= strobe_pad_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin sampling and alternate inputs.

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upper_pins_reg <= LATCH_RESET;
      strobe_pins_reg <= LATCH_RESET;
    end else if (ce_i) begin
      upper_pins_reg <= upper_pad_in_i;
      strobe_pins_reg <= strobe_pad_in_i;
    end
  end

  assign spi_miso_o = upper_pins_reg[MISO_BIT];
  assign spi_ss_b_o = upper_pins_reg[SS_T2_BIT];
  assign timer_two_clk_o = upper_pins_reg[SS_T2_BIT];
  assign timer_two_ext_control_o = upper_pins_reg[TIMER_TWO_EXT_CONTROL_BIT];
  assign pulse_alt_clock_o = upper_pins_reg[PULSE_CLK_BIT];
  assign uart_rxd_o = strobe_pins_reg[RXD_BIT];
  assign ext_irq_zero_o = strobe_pins_reg[IRQ0_BIT];
  assign ext_irq_one_o = strobe_pins_reg[IRQ1_BIT];
  assign count_in_zero_o = strobe_pins_reg[CNT0_BIT];
  assign count_in_one_o = strobe_pins_reg[CNT1_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Readback. Reading the latch avoids misreading a pin loaded low by,
  // say, a transistor base while its latch holds one.

  always_comb begin
    rdata_next = ALL_ZEROS;
    if (hit_upper) begin
      rdata_next = sfr_rd_latch_i ? upper_q : upper_pins_reg;
    end else if (hit_strobe) begin
      rdata_next = sfr_rd_latch_i ? strobe_q : strobe_pins_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= ALL_ZEROS;
    end else if (ce_i && sfr_rd_i) begin
      sfr_rdata_o <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_bit_wr_upper;
    ce_i && sfr_bit_wr_i && !sfr_wr_i && hit_upper;
  endsequence

  sequence s_latch_settled;
    ce_i [*2];
  endsequence

  a_latch_reset_ones: assert property (@(posedge clock_i)
    $rose(rst_b_i) |-> (upper_q == LATCH_RESET) && (strobe_q == LATCH_RESET))
    else $error("latch not all ones after reset");

  a_bit_write_only: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_bit_wr_upper |=> (upper_q[$past(sfr_bit_sel_i)] == $past(sfr_bit_val_i))
      && ((upper_q ^ $past(upper_q)) & ~(8'h01 << $past(sfr_bit_sel_i))) == ALL_ZEROS)
    else $error("bit write changed other bits");

  a_rmw_reads_latch: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && sfr_rd_i && sfr_rd_latch_i && hit_strobe |=> sfr_rdata_o == $past(strobe_q))
    else $error("latch read returned wrong value");

  a_plain_read_pins: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && sfr_rd_i && !sfr_rd_latch_i && hit_upper |=>
      sfr_rdata_o == $past(upper_pins_reg))
    else $error("pin read returned wrong value");

  a_upper_quasi_drive: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && !ext_mem_i && !spi_en_i && !pulse_a_en_i && !pulse_b_en_i |=>
      upper_pad_o.pull == $past(upper_q) && upper_pad_o.oe == ~$past(upper_q)
      && upper_pad_o.out == ALL_ZEROS)
    else $error("upper port quasi drive wrong");

  a_ext_addr_out: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && ext_mem_i && ext_high_sel_i |=>
      upper_pad_o.out == $past(ext_addr_i[HIGH_BYTE_LSB +: PORT_W])
      && upper_pad_o.oe == ALL_ONES)
    else $error("high address byte not driven");

  a_pulse_override: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && !ext_mem_i && pulse_a_en_i |=>
      upper_pad_o.pull[PULSE_A_BIT] == $past(pulse_out_a_i))
    else $error("pulse output did not override latch");

  a_strobe_low_latch: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && !strobe_q[WR_STB_BIT] |=>
      strobe_pad_o.oe[WR_STB_BIT] && !strobe_pad_o.out[WR_STB_BIT])
    else $error("strobe pin not held low by zero latch");

  a_strobe_settle: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (ce_i && sfr_wr_i && hit_strobe && sfr_wdata_i == ALL_ZEROS) ##1 s_latch_settled
      |-> strobe_pad_o.oe == ALL_ONES)
    else $error("strobe port zeros not driven");

endmodule
`default_nettype wire

// ---- tb/qbp_pin_model.sv ----
/*
 * Pin-level model of what stands outside the two quasi-bidirectional ports.
 * Assumes the pad bundle of qbp_pkg and a bench that says which pins an
 * external device pulls and to what level.
 */
`default_nettype none
module qbp_pin_model (
  input wire logic clock_i,
  input wire qbp_pkg::qbp_pad_t pad_i,
  input wire logic [qbp_pkg::PORT_W-1:0] ext_en_i,
  input wire logic [qbp_pkg::PORT_W-1:0] ext_val_i,
  output logic [qbp_pkg::PORT_W-1:0] wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import qbp_pkg::*;
  logic [PORT_W-1:0] last_q;
  // A floating pin shows the inverse of its last level, so a stale value never reads as good.
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pad_i.oe[i]) wire_o[i] = pad_i.out[i];
      else if (ext_en_i[i]) wire_o[i] = ext_val_i[i];
      else if (pad_i.pull[i]) wire_o[i] = 1'b1;
      else wire_o[i] = ~last_q[i];
    end
  end
  always_ff @(posedge clock_i) begin
    last_q <= wire_o;
  end
endmodule
`default_nettype wire

// ---- tb/qbp_ports_bench.sv ----
/*
 * Self-checking bench for qbp_ports: register reads, pad drive and pin samples.
 * Assumes qbp_pkg and the pin model; reads are checked through a queue.
 */
`default_nettype none
module qbp_ports_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import qbp_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [2:0] sfr_bit_sel_i = 3'h0;
  logic sfr_wr_i = 1'b0, sfr_bit_wr_i = 1'b0, sfr_bit_val_i = 1'b0;
  logic sfr_rd_i = 1'b0, sfr_rd_latch_i = 1'b0, ext_mem_i = 1'b0, ext_high_sel_i = 1'b0;
  logic [23:0] ext_addr_i = 24'h000000;
  logic pulse_a_en_i = 1'b0, pulse_b_en_i = 1'b0, pulse_out_a_i = 1'b1, pulse_out_b_i = 1'b1;
  logic spi_en_i = 1'b0, spi_sclk_i = 1'b1, spi_mosi_i = 1'b1, uart_rxd_out_i = 1'b1;
  logic uart_txd_i = 1'b1, wr_strobe_b_i = 1'b1, rd_strobe_b_i = 1'b1;
  logic [7:0] upper_pad_in_i, strobe_pad_in_i, sfr_rdata_o;
  logic [7:0] en_u = 8'h00, en_s = 8'h00, w = 8'hff, v, e;
  qbp_pad_t upper_pad_o, strobe_pad_o;
  logic spi_miso_o, spi_ss_b_o, timer_two_clk_o, timer_two_ext_control_o, pulse_alt_clock_o;
  logic uart_rxd_o, ext_irq_zero_o, ext_irq_one_o, count_in_zero_o, count_in_one_o;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int num_errors = 0, check_count = 0, cycles = 0;
  qbp_ports qbp_ports_inst (.clock_i, .rst_b_i, .ce_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_rd_i, .sfr_rd_latch_i, .sfr_rdata_o,
    .ext_mem_i, .ext_high_sel_i, .ext_addr_i, .pulse_a_en_i, .pulse_b_en_i, .pulse_out_a_i,
    .pulse_out_b_i, .spi_en_i, .spi_sclk_i, .spi_mosi_i, .uart_rxd_out_i, .uart_txd_i,
    .wr_strobe_b_i, .rd_strobe_b_i, .upper_pad_in_i, .strobe_pad_in_i, .upper_pad_o,
    .strobe_pad_o, .spi_miso_o, .spi_ss_b_o, .timer_two_clk_o, .timer_two_ext_control_o,
    .pulse_alt_clock_o, .uart_rxd_o, .ext_irq_zero_o, .ext_irq_one_o, .count_in_zero_o,
    .count_in_one_o);
  qbp_pin_model qbp_pin_model_inst (.clock_i, .pad_i(upper_pad_o), .ext_en_i(en_u),
    .ext_val_i(w), .wire_o(upper_pad_in_i));
  qbp_pin_model qbp_pin_model_b_inst (.clock_i, .pad_i(strobe_pad_o), .ext_en_i(en_s),
    .ext_val_i(w), .wire_o(strobe_pad_in_i));
  always #2.5 clock_i = ~clock_i;
  //////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    check_count++;
    if (seen !== expd) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  // Strobes drop and a cycle passes, so no strobe is set twice in one step.
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic bw,
                     input logic [2:0] b);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_bit_sel_i = b;
    sfr_bit_val_i = d[0];
    sfr_wr_i = ~bw;
    sfr_bit_wr_i = bw;
    tick();
    sfr_wr_i = 1'b0;
    sfr_bit_wr_i = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic lat, input logic [7:0] expd);
    sfr_addr_i = a;
    sfr_rd_latch_i = lat;
    sfr_rd_i = 1'b1;
    exp_q.push_back(expd);
    tick();
    sfr_rd_i = 1'b0;
    tick();
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Read data is valid the cycle after the read edge, so it is compared then.
  always @(posedge clock_i) begin
    if (rd_seen) check(sfr_rdata_o, exp_q.pop_front());
    rd_seen <= sfr_rd_i && ce_i;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(79));
    tick(12);
    check(upper_pad_o.oe, ALL_ZEROS);
    check(strobe_pad_o.pull, LATCH_RESET);
    rst_b_i = 1'b1;
    tick();
    rd(UPPER_PORT_ADDR, 1'b1, LATCH_RESET);
    rd(STROBE_PORT_ADDR, 1'b1, LATCH_RESET);
    en_u = ALL_ONES;
    en_s = ALL_ONES;
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      w = 8'($urandom());
      put(UPPER_PORT_ADDR, v, 1'b0, 3'h0);
      put(STROBE_PORT_ADDR, ~v, 1'b0, 3'h0);
      check(upper_pad_o.oe, ~v);
      check(upper_pad_o.pull, v);
      check(strobe_pad_o.oe, v);
      rd(UPPER_PORT_ADDR, 1'b1, v);
      rd(UPPER_PORT_ADDR, 1'b0, v & w);
      rd(STROBE_PORT_ADDR, 1'b0, ~v & w);
      e = v & w;
      check({pulse_alt_clock_o, timer_two_ext_control_o, timer_two_clk_o, spi_ss_b_o,
             spi_miso_o}, {e[7], e[4], e[3], e[3], e[2]});
      e = ~v & w;
      check({count_in_one_o, count_in_zero_o, ext_irq_one_o, ext_irq_zero_o, uart_rxd_o},
            {e[5], e[4], e[3], e[2], e[0]});
    end
    en_u = ALL_ZEROS;
    en_s = ALL_ZEROS;
    rd(8'hc0, 1'b0, ALL_ZEROS);
    ce_i = 1'b0;
    put(UPPER_PORT_ADDR, ~v, 1'b0, 3'h0);
    ce_i = 1'b1;
    ext_addr_i = 24'($urandom());
    ext_mem_i = 1'b1;
    for (int h = 0; h < 2; h++) begin
      ext_high_sel_i = h[0];
      tick(2);
      check(upper_pad_o.oe, ALL_ONES);
      check(upper_pad_o.out, ext_addr_i[MID_BYTE_LSB + 8 * h +: 8]);
    end
    ext_mem_i = 1'b0;
    rd(UPPER_PORT_ADDR, 1'b1, v);
    e = ALL_ZEROS;
    put(STROBE_PORT_ADDR, e, 1'b0, 3'h0);
    for (int b = 0; b < 8; b++) begin
      w[0] = 1'($urandom());
      put(STROBE_PORT_ADDR, {7'h00, w[0]}, 1'b1, 3'(b));
      e[b] = w[0];
      rd(STROBE_PORT_ADDR, 1'b1, e);
    end
    // One bit write on the upper port too, so its bit-write check has traffic.
    w = 8'($urandom());
    e = v;
    e[w[3:1]] = w[0];
    put(UPPER_PORT_ADDR, {7'h00, w[0]}, 1'b1, w[3:1]);
    rd(UPPER_PORT_ADDR, 1'b1, e);
    // Latch zeros under the pulse pins prove the override; ones under SPI pins let it show.
    put(UPPER_PORT_ADDR, 8'h03, 1'b0, 3'h0);
    put(STROBE_PORT_ADDR, 8'h55, 1'b0, 3'h0);
    spi_en_i = 1'b1;
    pulse_a_en_i = 1'b1;
    pulse_b_en_i = 1'b1;
    for (int k = 0; k < 2; k++) begin
      pulse_out_a_i = k[0];
      pulse_out_b_i = ~k[0];
      spi_sclk_i = k[0];
      spi_mosi_i = ~k[0];
      uart_txd_i = k[0];
      uart_rxd_out_i = k[0];
      wr_strobe_b_i = k[0];
      rd_strobe_b_i = k[0];
      tick(2);
      check(upper_pad_o.oe[6:5], {k[0], ~k[0]});
      check(upper_pad_o.oe[1:0], {k[0], ~k[0]});
      check(strobe_pad_o.oe, ~(8'h55 & (k[0] ? ALL_ONES : 8'h3c)));
    end
    tick(2);
    give_verdict();
  end
endmodule
`default_nettype wire
